// ===== erad_top.sv
`timescale 1ns/1ns
`include "erad_defs.svh"

module erad_top
  import erad_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic ce_b,
  input wire logic dc,
  input wire logic ab,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_b,
  input wire logic [1:0][`ERAD_NREG-1:0][7:0] status_regs,
  output erad_chan_t [1:0] cfg_o,
  output logic [7:0] feat_o,
  output erad_xfer_t wr_o,
  output erad_xfer_t rd_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (CHANNELS != 2)
    begin : g_chk
      $error("erad_top serves exactly two channels");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  erad_state_t s_q;
  erad_state_t s_d;
  erad_pins_t pins;
  logic [7:0] rd_val;
  logic rd_chan;
  logic [3:0] rd_addr;
  logic ext_rd;
  logic fifo_on;
  logic hw;
  logic act_rd;
  logic act_wr;
  logic w_chan;
  logic [3:0] w_addr;
  logic [7:0] w_data;

  assign pins = '{rd_b: rd_b, wr_b: wr_b, ce_b: ce_b, dc: dc, ab: ab, data: data_i};

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  // Chosen from the synchronised pins of the current cycle, so the byte
  // tracks the channel select held during the read strobe.
  always_comb
  begin
    rd_chan = s_q.sync2.ab;
    rd_addr = s_q.sync2.dc ? `ERAD_A_BUF : s_q.ptr;
    fifo_on = s_q.feat[`ERAD_FEAT_FIFO_BIT];
    ext_rd = s_q.feat[`ERAD_FEAT_ENH_BIT]
             & s_q.ch[rd_chan].enh_opt[`ERAD_EXT_READ_BIT];
    case (rd_addr)
      `ERAD_A_MODE:
      begin
        if (ext_rd)
          rd_val = s_q.ch[rd_chan].mode_setup;
        else
          rd_val = status_regs[rd_chan][rd_addr - `ERAD_LOW_ALIAS_OFS];
      end
      `ERAD_A_TXSET:
      begin
        if (ext_rd)
          rd_val = s_q.ch[rd_chan].tx_setup;
        else
          rd_val = status_regs[rd_chan][rd_addr - `ERAD_LOW_ALIAS_OFS];
      end
      `ERAD_A_FIFO_LO,
      `ERAD_A_FIFO_HI:
      begin
        if (fifo_on)
          rd_val = status_regs[rd_chan][rd_addr];
        else
          rd_val = status_regs[rd_chan][rd_addr - `ERAD_LOW_ALIAS_OFS];
      end
      `ERAD_A_RB9:
      begin
        if (ext_rd)
          rd_val = s_q.ch[rd_chan].rx_setup;
        else
          rd_val = status_regs[rd_chan][`ERAD_A_ALIAS9];
      end
      `ERAD_A_RB11:
      begin
        if (ext_rd)
          rd_val = s_q.ch[rd_chan].misc_ctrl;
        else
          rd_val = status_regs[rd_chan][`ERAD_A_ALIAS11];
      end
      `ERAD_A_RB14:
      begin
        if (ext_rd)
          rd_val = s_q.ch[rd_chan].enh_opt;
        else
          rd_val = status_regs[rd_chan][`ERAD_A_ALIAS14];
      end
      default:
      begin
        rd_val = status_regs[rd_chan][rd_addr];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Access sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.wr.valid = 1'b0;
    s_d.rd.valid = 1'b0;
    // Both strobes low is the hardware reset condition, not an access
    hw = !s_q.sync2.rd_b && !s_q.sync2.wr_b;
    act_rd = !hw && !s_q.sync2.ce_b && !s_q.sync2.rd_b;
    act_wr = !hw && !s_q.sync2.ce_b && !s_q.sync2.wr_b;
    s_d.hw_rst = hw;
    s_d.rd_act = act_rd;
    s_d.wr_act = act_wr;
    s_d.oe_b = !act_rd;
    if (act_rd || act_wr)
    begin
      s_d.held = s_q.sync2;
    end
    if (act_rd)
    begin
      s_d.dout = rd_val;
    end
    w_chan = s_q.held.ab;
    w_addr = s_q.held.dc ? `ERAD_A_BUF : s_q.ptr;
    w_data = s_q.held.data;
    if (hw)
    begin
      s_d.ptr = `ERAD_RST_PTR;
      s_d.feat = `ERAD_RST_BYTE;
      for (int i = 0; i < CHANNELS; i++)
      begin
        s_d.ch[i] = {6{`ERAD_RST_BYTE}};
      end
      s_d.rd_act = 1'b0;
      s_d.wr_act = 1'b0;
    end
    else if (s_q.wr_act && !act_wr)
    begin
      // Write completes on the trailing edge of the strobe
      if (!s_q.held.dc)
      begin
        s_d.ptr = `ERAD_RST_PTR;
      end
      case (w_addr)
        `ERAD_A_CMD:
        begin
          s_d.ptr = {w_data[`ERAD_CMD_MSB:`ERAD_CMD_LSB] == `ERAD_CMD_POINT_HIGH,
                     w_data[`ERAD_PTR_MSB:0]};
          s_d.wr = '{valid: 1'b1, chan: w_chan, addr: w_addr, data: w_data};
        end
        `ERAD_A_RXSET:
        begin
          s_d.ch[w_chan].rx_setup = w_data;
        end
        `ERAD_A_MODE:
        begin
          s_d.ch[w_chan].mode_setup = w_data;
        end
        `ERAD_A_TXSET:
        begin
          s_d.ch[w_chan].tx_setup = w_data;
        end
        `ERAD_A_FLAG:
        begin
          if (s_q.feat[`ERAD_FEAT_ENH_BIT])
            s_d.ch[w_chan].enh_opt = w_data;
          else
            s_d.ch[w_chan].flag_pattern = w_data;
        end
        `ERAD_A_MISC:
        begin
          s_d.ch[w_chan].misc_ctrl = w_data;
        end
        `ERAD_A_FEAT:
        begin
          // Both enables stored as written, neither gates the other
          s_d.feat = w_data;
        end
        default:
        begin
          s_d.wr = '{valid: 1'b1, chan: w_chan, addr: w_addr, data: w_data};
        end
      endcase
    end
    else if (s_q.rd_act && !act_rd)
    begin
      if (!s_q.held.dc)
      begin
        s_d.ptr = `ERAD_RST_PTR;
      end
      s_d.rd = '{valid: 1'b1, chan: w_chan, addr: w_addr, data: s_q.dout};
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.sync1 <= '{rd_b: 1'b1, wr_b: 1'b1, ce_b: 1'b1, dc: 1'b0, ab: 1'b0, data: 8'h00};
      s_q.sync2 <= '{rd_b: 1'b1, wr_b: 1'b1, ce_b: 1'b1, dc: 1'b0, ab: 1'b0, data: 8'h00};
      s_q.oe_b <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign data_o = s_q.dout;
  assign data_oe_b = s_q.oe_b;
  assign cfg_o = s_q.ch;
  assign feat_o = s_q.feat;
  assign wr_o = s_q.wr;
  assign rd_o = s_q.rd;

endmodule

// ===== erad_defs.svh
// What this block does
// - While feature enable bit D0 is 1 a write at address 7 lands in the enhancement option register, otherwise in the flag pattern register.
// - With extended read (option bit D6) on, the receive setup, mode, transmit setup and misc control registers become readable.
// - With extended read on, reading upper address 9 returns the channel's receive setup register.
// - With extended read on, reading upper address 11 returns the channel's misc control register.
// - With extended read on, reading upper address 14 returns the channel's enhancement option register.
// - Extended read counts only while feature enable bit D0 is also 1.
// - The frame status FIFO enable (D2) and the link enhancement enable (D0) are independent bits.
// - A control access goes to the pointed register, after which the pointer returns to zero; a write to register 0 loads the pointer instead.
// - Command field D5..D3 equal to 001 with the pointer bits selects registers 8 to 15.
// - With feature enable bit D2 set, reads at addresses 6 and 7 return the FIFO status images.
`ifndef ERAD_DEFS_SVH
`define ERAD_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ERAD_NREG 16
`define ERAD_A_CMD 4'h0
`define ERAD_A_RXSET 4'h3
`define ERAD_A_MODE 4'h4
`define ERAD_A_TXSET 4'h5
`define ERAD_A_FIFO_LO 4'h6
`define ERAD_A_FIFO_HI 4'h7
`define ERAD_A_FLAG 4'h7
`define ERAD_A_BUF 4'h8
`define ERAD_A_RB9 4'h9
`define ERAD_A_MISC 4'ha
`define ERAD_A_RB11 4'hb
`define ERAD_A_RB14 4'he
`define ERAD_A_FEAT 4'hf
`define ERAD_A_ALIAS9 4'hd
`define ERAD_A_ALIAS11 4'hf
`define ERAD_A_ALIAS14 4'ha
`define ERAD_LOW_ALIAS_OFS 4'h4

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define ERAD_FEAT_ENH_BIT 0
`define ERAD_FEAT_FIFO_BIT 2
`define ERAD_EXT_READ_BIT 6
`define ERAD_PTR_MSB 2
`define ERAD_CMD_MSB 5
`define ERAD_CMD_LSB 3
`define ERAD_CMD_POINT_HIGH 3'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ERAD_RST_BYTE 8'h00
`define ERAD_RST_PTR 4'h0

`endif

// ===== erad_pkg.sv
package erad_pkg;

  // Host bus pins as sampled
  typedef struct packed {
    logic rd_b;
    logic wr_b;
    logic ce_b;
    logic dc;
    logic ab;
    logic [7:0] data;
  } erad_pins_t;

  // Per-channel write registers held by this block
  typedef struct packed {
    logic [7:0] rx_setup;
    logic [7:0] mode_setup;
    logic [7:0] tx_setup;
    logic [7:0] flag_pattern;
    logic [7:0] enh_opt;
    logic [7:0] misc_ctrl;
  } erad_chan_t;

  // One finished access reported to the datapath
  typedef struct packed {
    logic valid;
    logic chan;
    logic [3:0] addr;
    logic [7:0] data;
  } erad_xfer_t;

  typedef struct packed {
    erad_pins_t sync1;
    erad_pins_t sync2;
    erad_pins_t held;
    logic wr_act;
    logic rd_act;
    logic hw_rst;
    logic [3:0] ptr;
    logic [7:0] feat;
    erad_chan_t [1:0] ch;
    logic [7:0] dout;
    logic oe_b;
    erad_xfer_t wr;
    erad_xfer_t rd;
  } erad_state_t;

endpackage

// ===== erad_monitor.sv
`timescale 1ns/1ns
`include "erad_defs.svh"
module erad_monitor
  import erad_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic ce_b,
  input wire logic data_oe_b,
  input wire logic [1:0][`ERAD_NREG-1:0][7:0] status_regs,
  input wire erad_chan_t [1:0] cfg_o,
  input wire logic [7:0] feat_o,
  input wire erad_xfer_t wr_o,
  input wire erad_xfer_t rd_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic ext;
  erad_chan_t rcfg;
  assign rcfg = cfg_o[rd_o.chan];
  assign ext = rd_o.valid & feat_o[0] & rcfg.enh_opt[6];
  a_read_drive: assert property ((!rd_b && !ce_b && wr_b)[*5] |-> !data_oe_b)
    else $error("read byte not driven");
  a_cfg_hold: assert property ((rd_b && wr_b)[*7] |-> $stable(cfg_o) && $stable(feat_o))
    else $error("config moved while idle");
  a_rd_pulse: assert property (rd_o.valid |=> !rd_o.valid)
    else $error("read pulse too long");
  a_ext_nine: assert property (ext && rd_o.addr == 4'h9 |-> rd_o.data == rcfg.rx_setup)
    else $error("addr 9 readback");
  a_ext_eleven: assert property (ext && rd_o.addr == 4'hb |-> rd_o.data == rcfg.misc_ctrl)
    else $error("addr 11 readback");
  a_ext_fourteen: assert property (ext && rd_o.addr == 4'he |-> rd_o.data == rcfg.enh_opt)
    else $error("addr 14 readback");
  a_alias_nine: assert property (rd_o.valid && !ext && rd_o.addr == 4'h9
    |-> rd_o.data == status_regs[rd_o.chan][4'hd]) else $error("addr 9 alias");
  a_fifo_six: assert property (rd_o.valid && feat_o[2] && rd_o.addr == 4'h6
    |-> rd_o.data == status_regs[rd_o.chan][4'h6]) else $error("addr 6 fifo");
  a_wr_pulse: assert property (wr_o.valid |=> !wr_o.valid)
    else $error("write pulse too long");
  a_wr_held: assert property (wr_o.valid |-> wr_o.addr != 4'h7 && wr_o.addr != 4'hf)
    else $error("held register write forwarded");
endmodule
bind erad_top erad_monitor #(.CHANNELS(CHANNELS)) mon (.clk(clk), .rst_b(rst_b), .rd_b(rd_b),
  .wr_b(wr_b), .ce_b(ce_b), .data_oe_b(data_oe_b), .status_regs(status_regs), .cfg_o(cfg_o),
  .feat_o(feat_o), .wr_o(wr_o), .rd_o(rd_o));

// ===== erad_host.sv
`timescale 1ns/1ns
module erad_host
  import erad_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] data_o,
  input wire logic data_oe_b,
  output logic rd_b,
  output logic wr_b,
  output logic ce_b,
  output logic dc,
  output logic ab,
  output logic [7:0] data_i
);
  initial
  begin
    {rd_b, wr_b, ce_b, dc, ab} = 5'h1c;
    data_i = 8'h00;
  end
  // Five edges low so the two sync flops settle; six high so a write lands first
  task automatic cyc(input logic r, input logic a, input logic d, input logic [7:0] v,
    output logic [7:0] q);
    q = 8'hxx;
    @(posedge clk);
    {ab, dc, data_i, ce_b, rd_b, wr_b} <= {a, d, v, 1'b0, !r, r};
    repeat (5) @(posedge clk);
    if (!data_oe_b) q = data_o;
    // Released data lines show the inverse so stale values cannot pass
    {data_i, ce_b, rd_b, wr_b} <= {~v, 3'h7};
    repeat (6) @(posedge clk);
  endtask
  // Both strobes low together is a hardware reset whatever chip enable shows
  task automatic hwr();
    @(posedge clk);
    {rd_b, wr_b} <= 2'h0;
    repeat (5) @(posedge clk);
    {rd_b, wr_b} <= 2'h3;
    repeat (6) @(posedge clk);
  endtask
  task automatic acc(input logic r, input logic a, input logic [3:0] n, input logic [7:0] v,
    output logic [7:0] q);
    cyc(1'b0, a, 1'b0, {4'h0, n}, q);
    cyc(r, a, 1'b0, v, q);
  endtask
endmodule

// ===== test_enhanced_register_access_decode.sv
`timescale 1ns/1ns
`include "erad_defs.svh"
module test_enhanced_register_access_decode
  import erad_pkg::*;
;
  logic clk, rst_b, rd_b, wr_b, ce_b, dc, ab, data_oe_b;
  logic [7:0] data_i, data_o, feat_o, q;
  logic [1:0][`ERAD_NREG-1:0][7:0] status_regs;
  erad_chan_t [1:0] cfg_o;
  erad_xfer_t wr_o, rd_o;
  int error_cnt = 0;
  int tests_run = 0;
  erad_top #(.CHANNELS(2)) dut (.clk(clk), .rst_b(rst_b), .rd_b(rd_b), .wr_b(wr_b), .ce_b(ce_b),
    .dc(dc), .ab(ab), .data_i(data_i), .data_o(data_o), .data_oe_b(data_oe_b),
    .status_regs(status_regs), .cfg_o(cfg_o), .feat_o(feat_o), .wr_o(wr_o), .rd_o(rd_o));
  erad_host host (.clk(clk), .data_o(data_o), .data_oe_b(data_oe_b), .rd_b(rd_b),
    .wr_b(wr_b), .ce_b(ce_b), .dc(dc), .ab(ab), .data_i(data_i));
  function automatic logic [7:0] st(input logic c, input logic [3:0] a);
    return {3'h0, c, a};
  endfunction
  task automatic chk(input string nm, input logic [104:0] got, input logic [104:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic a, input logic [3:0] n, input logic [7:0] v);
    host.acc(1'b0, a, n, v, q);
  endtask
  task automatic rdc(input logic a, input logic [3:0] n, input logic [7:0] e);
    host.acc(1'b1, a, n, 8'h00, q);
    chk($sformatf("read %h", n), q, e);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    for (int i = 0; i < 32; i++) status_regs[i[4]][i[3:0]] = st(i[4], i[3:0]);
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial
  begin
    rst_b = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    chk("reset", {cfg_o, feat_o, data_oe_b}, {104'h0, 1'b1});
    wr(1'b1, 4'h7, 8'h5a);
    chk("flag", {cfg_o[1].flag_pattern, cfg_o[1].enh_opt}, 16'h5a00);
    rdc(1'b1, 4'h6, st(1'b1, 4'h2));
    rdc(1'b1, 4'h9, st(1'b1, 4'hd));
    rdc(1'b1, 4'h4, st(1'b1, 4'h0));
    wr(1'b1, 4'hf, 8'h01);
    wr(1'b1, 4'h7, 8'h40);
    chk("enh", {cfg_o[1].flag_pattern, cfg_o[1].enh_opt}, 16'h5a40);
    wr(1'b1, 4'h3, 8'h33);
    wr(1'b1, 4'h4, 8'h44);
    wr(1'b1, 4'h5, 8'h55);
    wr(1'b1, 4'ha, 8'haa);
    rdc(1'b1, 4'h9, 8'h33);
    rdc(1'b1, 4'hb, 8'haa);
    rdc(1'b1, 4'he, 8'h40);
    rdc(1'b1, 4'h4, 8'h44);
    rdc(1'b1, 4'h5, 8'h55);
    rdc(1'b0, 4'h9, st(1'b0, 4'hd));
    rdc(1'b1, 4'h7, st(1'b1, 4'h3));
    wr(1'b1, 4'hf, 8'h04);
    chk("feat", feat_o, 8'h04);
    rdc(1'b1, 4'h9, st(1'b1, 4'hd));
    rdc(1'b1, 4'hb, st(1'b1, 4'hf));
    rdc(1'b1, 4'he, st(1'b1, 4'ha));
    rdc(1'b1, 4'h6, st(1'b1, 4'h6));
    rdc(1'b1, 4'h7, st(1'b1, 4'h7));
    wr(1'b1, 4'hf, 8'h05);
    rdc(1'b1, 4'he, 8'h40);
    host.cyc(1'b0, 1'b1, 1'b0, 8'h03, q);
    host.cyc(1'b1, 1'b1, 1'b0, 8'h00, q);
    chk("pointed", q, st(1'b1, 4'h3));
    host.cyc(1'b1, 1'b1, 1'b0, 8'h00, q);
    chk("cleared", q, st(1'b1, 4'h0));
    host.cyc(1'b1, 1'b1, 1'b1, 8'h00, q);
    chk("buffer", q, st(1'b1, 4'h8));
    // Hardware reset must drop a pointer left set and every stored byte
    host.cyc(1'b0, 1'b1, 1'b0, 8'h03, q);
    host.hwr();
    chk("hw reset", {cfg_o, feat_o}, 104'h0);
    host.cyc(1'b1, 1'b1, 1'b0, 8'h00, q);
    chk("hw pointer", q, st(1'b1, 4'h0));
    close_out();
  end
endmodule
